// file: design/port_config_keypad_wake.sv
`timescale 1ns/100ps
module port_config_keypad_wake #(
    parameter int PORT_W = port_cfg_pkg::PORT_W,
    parameter int NPIN   = port_cfg_pkg::NPIN
) (
    input  wire logic            i_clock,
    input  wire logic            i_rst,
    input  wire logic            i_psel,
    input  wire logic            i_penable,
    input  wire logic            i_pwrite,
    input  wire logic [7:0]      i_paddr,
    input  wire logic [31:0]     i_pwdata,
    output logic      [31:0]     o_prdata,
    output logic                 o_pready,
    output logic                 o_pslverr,
    input  wire logic            i_cfg_reset_high,
    input  wire logic            i_cfg_internal_reset,
    input  wire logic            i_cfg_crystal_osc,
    input  wire logic [NPIN-1:0] i_pin,
    output logic      [NPIN-1:0] o_very_weak_pu,
    output logic      [NPIN-1:0] o_weak_pu,
    output logic      [NPIN-1:0] o_strong_pu,
    output logic      [NPIN-1:0] o_pull_down,
    output logic      [NPIN-1:0] o_input_en,
    output logic      [NPIN-1:0] o_schmitt_sel,
    output logic                 o_timer0_toggle_en,
    output logic                 o_timer1_toggle_en,
    output logic                 o_clkout_en,
    output logic                 o_irq
);
    localparam int NPORT = port_cfg_pkg::NPORT;

    logic [PORT_W-1:0] latch_reg [NPORT];
    logic [PORT_W-1:0] cfg_a_reg [NPORT];
    logic [PORT_W-1:0] cfg_b_reg [NPORT];
    logic [PORT_W-1:0] key_mask_reg;
    logic              key_active_reg;
    logic              keypad_flag_reg;
    logic              irq_en_reg;
    logic              int_rst_reg;
    logic              xtal_reg;
    logic [NPIN-1:0]   pin_meta_reg;
    logic [NPIN-1:0]   pin_sync_reg;
    logic [31:0]       rd_next;
    logic              hit_next;
    logic              setup;
    logic              wr;
    logic              key_low;
    logic              flag_clear;

    function automatic logic port_hit(input logic [7:0] addr,
                                      input int         port,
                                      input logic [7:0] off);
        port_hit = (addr == 8'(port * port_cfg_pkg::OFF_STRIDE + off));
    endfunction : port_hit

    assign setup = i_psel & ~i_penable;
    assign wr    = i_psel & i_penable & i_pwrite & o_pready;

    // Straps are sampled while reset is held
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            int_rst_reg <= i_cfg_internal_reset;
            xtal_reg    <= i_cfg_crystal_osc;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= i_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_ff @(posedge i_clock) begin
        for (int p = 0; p < NPORT; p++) begin
            if (i_rst) begin
                latch_reg[p] <= {PORT_W{i_cfg_reset_high}};
                cfg_a_reg[p] <= port_cfg_pkg::CFG_RESET;
                cfg_b_reg[p] <= port_cfg_pkg::CFG_RESET;
            end else if (wr) begin
                if (port_hit(i_paddr, p, port_cfg_pkg::OFF_LATCH)) begin
                    latch_reg[p] <= i_pwdata[PORT_W-1:0];
                end
                if (port_hit(i_paddr, p, port_cfg_pkg::OFF_CFG_A)) begin
                    cfg_a_reg[p] <= i_pwdata[PORT_W-1:0];
                end
                if (port_hit(i_paddr, p, port_cfg_pkg::OFF_CFG_B)) begin
                    cfg_b_reg[p] <= i_pwdata[PORT_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            key_mask_reg   <= '0;
            key_active_reg <= 1'b0;
            irq_en_reg     <= 1'b0;
        end else if (wr) begin
            if (i_paddr == port_cfg_pkg::OFF_KEY_MASK) begin
                key_mask_reg <= i_pwdata[PORT_W-1:0];
            end
            if (i_paddr == port_cfg_pkg::OFF_AUX) begin
                key_active_reg <= i_pwdata[port_cfg_pkg::AUX_ACTIVE_BIT];
            end
            if (i_paddr == port_cfg_pkg::OFF_IRQ_EN) begin
                irq_en_reg <= i_pwdata[port_cfg_pkg::IRQ_KEYPAD_BIT];
            end
        end
    end

    assign key_low = key_active_reg
                     & |(key_mask_reg & ~pin_sync_reg[PORT_W-1:0]);

    assign flag_clear = wr & (
        ((i_paddr == port_cfg_pkg::OFF_AUX)
         & ~i_pwdata[port_cfg_pkg::AUX_FLAG_BIT])
        | ((i_paddr == port_cfg_pkg::OFF_IRQ_CLR)
         & i_pwdata[port_cfg_pkg::IRQ_KEYPAD_BIT]));

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            keypad_flag_reg <= 1'b0;
        end else if (key_low) begin
            keypad_flag_reg <= 1'b1;
        end else if (flag_clear) begin
            keypad_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        o_irq <= !i_rst && keypad_flag_reg && irq_en_reg;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_timer0_toggle_en <= 1'b0;
            o_timer1_toggle_en <= 1'b0;
            o_clkout_en        <= 1'b0;
        end else begin
            o_timer0_toggle_en <= cfg_a_reg[2][port_cfg_pkg::P2A_T0_TOGGLE];
            o_timer1_toggle_en <= cfg_a_reg[2][port_cfg_pkg::P2A_T1_TOGGLE];
            o_clkout_en        <= cfg_a_reg[2][port_cfg_pkg::P2A_CLKOUT];
        end
    end

    always_comb begin
        rd_next  = port_cfg_pkg::RD_ZERO;
        hit_next = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            if (port_hit(i_paddr, p, port_cfg_pkg::OFF_LATCH)) begin
                rd_next  = 32'(latch_reg[p]);
                hit_next = 1'b1;
            end
            if (port_hit(i_paddr, p, port_cfg_pkg::OFF_CFG_A)) begin
                rd_next  = 32'(cfg_a_reg[p]);
                hit_next = 1'b1;
            end
            if (port_hit(i_paddr, p, port_cfg_pkg::OFF_CFG_B)) begin
                rd_next  = 32'(cfg_b_reg[p]);
                hit_next = 1'b1;
            end
        end
        case (i_paddr)
            port_cfg_pkg::OFF_PIN_READ: begin
                rd_next  = 32'(pin_sync_reg & o_input_en);
                hit_next = 1'b1;
            end
            port_cfg_pkg::OFF_KEY_MASK: begin
                rd_next  = 32'(key_mask_reg);
                hit_next = 1'b1;
            end
            port_cfg_pkg::OFF_AUX: begin
                rd_next  = 32'({key_active_reg, keypad_flag_reg});
                hit_next = 1'b1;
            end
            port_cfg_pkg::OFF_IRQ_STAT: begin
                rd_next  = 32'(keypad_flag_reg);
                hit_next = 1'b1;
            end
            port_cfg_pkg::OFF_IRQ_CLR: begin
                hit_next = 1'b1;
            end
            port_cfg_pkg::OFF_IRQ_EN: begin
                rd_next  = 32'(irq_en_reg);
                hit_next = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // One wait-free access phase after each setup
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= port_cfg_pkg::RD_ZERO;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup & ~hit_next;
            if (setup) begin
                o_prdata <= i_pwrite ? port_cfg_pkg::RD_ZERO : rd_next;
            end
        end
    end

    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        localparam int P = i / PORT_W;
        localparam int B = i % PORT_W;
        localparam bit FIX_OD = (i == port_cfg_pkg::FIXED_OD_PIN_A)
                             || (i == port_cfg_pkg::FIXED_OD_PIN_B);
        localparam bit RST_PIN = (i == port_cfg_pkg::RESET_SHARED_PIN);
        localparam bit OSC_PIN = (i == port_cfg_pkg::OSC_PIN_OUT)
                              || (i == port_cfg_pkg::OSC_PIN_IN);
        logic dis;

        assign dis = (RST_PIN && !int_rst_reg) || (OSC_PIN && xtal_reg);

        pin_drive_cell u_cell (
            .i_clock        (i_clock),
            .i_rst          (i_rst),
            .i_mode         ({cfg_a_reg[P][B], cfg_b_reg[P][B]}),
            .i_latch        (latch_reg[P][B]),
            .i_pin          (pin_sync_reg[i]),
            .i_force_od     (FIX_OD),
            .i_force_in     (RST_PIN),
            .i_disable      (dis),
            .o_very_weak_pu (o_very_weak_pu[i]),
            .o_weak_pu      (o_weak_pu[i]),
            .o_strong_pu    (o_strong_pu[i]),
            .o_pull_down    (o_pull_down[i]),
            .o_input_en     (o_input_en[i])
        );

        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                o_schmitt_sel[i] <= FIX_OD || RST_PIN;
            end else begin
                o_schmitt_sel[i] <= FIX_OD || RST_PIN
                    || cfg_a_reg[2][port_cfg_pkg::P2A_SCHMITT_LSB + P];
            end
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sync_delay_a: assert property (
        !$past(i_rst) && !$past(i_rst, 2)
        |-> pin_sync_reg == $past(i_pin, 2))
        else $error("pin synchroniser delay wrong");
    flag_set_a: assert property (
        key_low |=> keypad_flag_reg)
        else $error("keypad flag not set by low pin");
    flag_hold_a: assert property (
        keypad_flag_reg && !flag_clear |=> keypad_flag_reg)
        else $error("keypad flag dropped without clear");
    wake_irq_a: assert property (
        keypad_flag_reg && irq_en_reg |=> o_irq)
        else $error("keypad request not raised");
    reset_mode_a: assert property (
        $past(i_rst) |-> cfg_a_reg[0] == '0 && cfg_b_reg[0] == '0)
        else $error("mode not quasi after reset");
    reset_level_a: assert property (
        $past(i_rst)
        |-> latch_reg[1] == {PORT_W{$past(i_cfg_reset_high)}})
        else $error("latch reset level wrong");
    vweak_follow_a: assert property (
        cfg_a_reg[0][0] == 1'b0 && cfg_b_reg[0][0] == 1'b0
        && latch_reg[0][0] |=> o_very_weak_pu[0])
        else $error("very weak pull-up missing");
    weak_drop_a: assert property (
        !pin_sync_reg[0] |=> !o_weak_pu[0])
        else $error("weak pull-up on with pin low");
    push_pull_a: assert property (
        !cfg_a_reg[0][1] && cfg_b_reg[0][1]
        |=> o_strong_pu[1] == $past(latch_reg[0][1])
            && o_pull_down[1] == !$past(latch_reg[0][1]))
        else $error("push-pull drive wrong");
    fixed_od_a: assert property (
        !o_strong_pu[port_cfg_pkg::FIXED_OD_PIN_A]
        && !o_weak_pu[port_cfg_pkg::FIXED_OD_PIN_B])
        else $error("fixed open-drain pin pulled up");
    rst_pin_a: assert property (
        !int_rst_reg |=> !o_input_en[port_cfg_pkg::RESET_SHARED_PIN]
                         && !o_pull_down[port_cfg_pkg::RESET_SHARED_PIN])
        else $error("reset pin used as port");
    osc_off_a: assert property (
        xtal_reg |=> !o_input_en[port_cfg_pkg::OSC_PIN_IN]
                     && !o_pull_down[port_cfg_pkg::OSC_PIN_OUT])
        else $error("oscillator pin active");
    fixed_schmitt_a: assert property (
        o_schmitt_sel[port_cfg_pkg::FIXED_OD_PIN_A]
        && o_schmitt_sel[port_cfg_pkg::RESET_SHARED_PIN])
        else $error("fixed pin not Schmitt");

    flag_set_c: cover property (key_low ##1 keypad_flag_reg);
    irq_clear_c: cover property (o_irq ##[1:20] !keypad_flag_reg);
    strong_c: cover property (o_strong_pu[0] [*2] ##1 !o_strong_pu[0]);
    masked_key_c: cover property (key_active_reg && !key_low
                                  && |(~pin_sync_reg[PORT_W-1:0]));
    bus_err_c: cover property (o_pready && o_pslverr);
endmodule : port_config_keypad_wake

// file: shared/port_cfg_pkg.sv
package port_cfg_pkg;
    localparam int         PORT_W           = 8;
    localparam int         NPORT            = 3;
    localparam int         P2_PINS          = 2;
    localparam int         NPIN             = 2 * PORT_W + P2_PINS;
    localparam int         STRONG_CYCLES    = 2;
    localparam logic [7:0] OFF_STRIDE       = 8'h0C;
    localparam logic [7:0] OFF_LATCH        = 8'h00;
    localparam logic [7:0] OFF_CFG_A        = 8'h04;
    localparam logic [7:0] OFF_CFG_B        = 8'h08;
    localparam logic [7:0] OFF_PIN_READ     = 8'h24;
    localparam logic [7:0] OFF_KEY_MASK     = 8'h28;
    localparam logic [7:0] OFF_AUX          = 8'h2C;
    localparam logic [7:0] OFF_IRQ_STAT     = 8'h30;
    localparam logic [7:0] OFF_IRQ_CLR      = 8'h34;
    localparam logic [7:0] OFF_IRQ_EN       = 8'h38;
    localparam logic [1:0] MODE_QUASI       = 2'h0;
    localparam logic [1:0] MODE_PUSH        = 2'h1;
    localparam logic [1:0] MODE_INPUT       = 2'h2;
    localparam logic [1:0] MODE_OPEN_DRAIN  = 2'h3;
    localparam int         P2A_SCHMITT_LSB  = 2;
    localparam int         P2A_T0_TOGGLE    = 5;
    localparam int         P2A_T1_TOGGLE    = 6;
    localparam int         P2A_CLKOUT       = 7;
    localparam int         AUX_FLAG_BIT     = 0;
    localparam int         AUX_ACTIVE_BIT   = 1;
    localparam int         IRQ_KEYPAD_BIT   = 0;
    localparam int         FIXED_OD_PIN_A   = 10;
    localparam int         FIXED_OD_PIN_B   = 11;
    localparam int         RESET_SHARED_PIN = 13;
    localparam int         OSC_PIN_OUT      = 16;
    localparam int         OSC_PIN_IN       = 17;
    localparam logic [7:0] CFG_RESET        = 8'h00;
    localparam logic [31:0] RD_ZERO         = 32'h0000_0000;
endpackage : port_cfg_pkg

// file: design/pin_drive_cell.sv
`timescale 1ns/100ps
module pin_drive_cell #(
    parameter int STRONG_CYCLES = port_cfg_pkg::STRONG_CYCLES
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_latch,
    input  wire logic       i_pin,
    input  wire logic       i_force_od,
    input  wire logic       i_force_in,
    input  wire logic       i_disable,
    output logic            o_very_weak_pu,
    output logic            o_weak_pu,
    output logic            o_strong_pu,
    output logic            o_pull_down,
    output logic            o_input_en
);
    localparam int CW = $clog2(STRONG_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(STRONG_CYCLES - 1);

    logic [1:0]    mode;
    logic          is_qb;
    logic          is_pp;
    logic          is_od;
    logic          rise;
    logic          latch_prev_reg;
    logic [CW-1:0] strong_cnt_reg;

    always_comb begin
        if (i_force_od) begin
            mode = port_cfg_pkg::MODE_OPEN_DRAIN;
        end else if (i_force_in) begin
            mode = port_cfg_pkg::MODE_INPUT;
        end else begin
            mode = i_mode;
        end
    end

    assign is_qb = (mode == port_cfg_pkg::MODE_QUASI);
    assign is_pp = (mode == port_cfg_pkg::MODE_PUSH);
    assign is_od = (mode == port_cfg_pkg::MODE_OPEN_DRAIN);
    assign rise  = is_qb & i_latch & ~latch_prev_reg;

    always_ff @(posedge i_clock) begin
        latch_prev_reg <= i_rst ? 1'b1 : i_latch;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || !is_qb) begin
            strong_cnt_reg <= '0;
        end else if (rise) begin
            strong_cnt_reg <= LOAD;
        end else if (strong_cnt_reg != '0) begin
            strong_cnt_reg <= strong_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || i_disable) begin
            o_very_weak_pu <= 1'b0;
            o_weak_pu      <= 1'b0;
            o_strong_pu    <= 1'b0;
            o_pull_down    <= 1'b0;
            o_input_en     <= !i_rst && !i_disable;
        end else begin
            o_very_weak_pu <= is_qb & i_latch;
            o_weak_pu      <= is_qb & i_latch & i_pin;
            // strong pull-up: push-pull high level, or quasi-bidirectional rise pulse
            // Pulse tail only counts while still quasi-bidirectional
            o_strong_pu    <= (is_pp & i_latch) | rise
                              | (is_qb & (strong_cnt_reg != '0));
            o_pull_down    <= (is_qb | is_pp | is_od) & ~i_latch;
            o_input_en     <= 1'b1;
        end
    end

    strong_two_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        rise && !i_disable |=> o_strong_pu [*2])
        else $error("strong pull-up pulse too short");
    strong_end_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        rise && !i_disable ##1 (is_qb && !rise) [*2] |=> !o_strong_pu)
        else $error("strong pull-up pulse too long");
    od_no_pullup_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        is_od |=> !o_very_weak_pu && !o_weak_pu && !o_strong_pu)
        else $error("pull-up active in open drain");
endmodule : pin_drive_cell

// file: tb/pin_partner.sv
`timescale 1ns/100ps
module pin_partner #(
    parameter int NPIN = port_cfg_pkg::NPIN
) (
    input  wire logic            i_clock,
    input  wire logic [NPIN-1:0] i_very_weak_pu,
    input  wire logic [NPIN-1:0] i_weak_pu,
    input  wire logic [NPIN-1:0] i_strong_pu,
    input  wire logic [NPIN-1:0] i_pull_down,
    input  wire logic [NPIN-1:0] i_key_low,
    output logic      [NPIN-1:0] o_pin
);
    logic [NPIN-1:0] float_reg = '0;
    logic [NPIN-1:0] pull_up;

    assign pull_up = i_very_weak_pu | i_weak_pu | i_strong_pu;

    // Undriven pins wander so no stale level is trusted
    always_ff @(posedge i_clock) begin
        float_reg <= ~o_pin;
    end

    assign o_pin = ~(i_key_low | i_pull_down) & (pull_up | float_reg);
endmodule : pin_partner

// file: tb/port_config_keypad_wake_test.sv
`timescale 1ns/100ps
module port_config_keypad_wake_test;
    localparam int N = port_cfg_pkg::NPIN;
    logic          clock = 1'b0;
    logic          rst = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready, pslverr, t0, t1, ck, irq;
    logic          rst_high = 1'b1;
    logic          int_rst = 1'b0;
    logic          xtal = 1'b0;
    logic [N-1:0]  key_low = '0;
    logic [N-1:0]  pin, vw, wk, st, pd, ien, sch;
    int            mismatches = 0;
    int            comparisons = 0;

    always #20 clock = ~clock;

    port_config_keypad_wake i_dut (
        .i_clock(clock), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_cfg_reset_high(rst_high), .i_cfg_internal_reset(int_rst),
        .i_cfg_crystal_osc(xtal), .i_pin(pin), .o_very_weak_pu(vw),
        .o_weak_pu(wk), .o_strong_pu(st), .o_pull_down(pd),
        .o_input_en(ien), .o_schmitt_sel(sch), .o_timer0_toggle_en(t0),
        .o_timer1_toggle_en(t1), .o_clkout_en(ck), .o_irq(irq));

    pin_partner #(.NPIN(N)) i_pins (
        .i_clock(clock), .i_very_weak_pu(vw), .i_weak_pu(wk),
        .i_strong_pu(st), .i_pull_down(pd), .i_key_low(key_low),
        .o_pin(pin));

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Access phase lasts until pready is seen at a rising edge
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, r, x);
        check("read_err", {31'h0, e}, 32'h0);
    endtask : rdchk

    task automatic ncyc(input int n);
        repeat (n) @(negedge clock);
    endtask : ncyc

    task automatic press(input logic [N-1:0] k);
        @(posedge clock);
        key_low <= k;
    endtask : press

    task automatic do_reset(input logic h, input logic ir, input logic x);
        @(posedge clock);
        rst <= 1'b1;
        rst_high <= h;
        int_rst <= ir;
        xtal <= x;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        ncyc(2);
    endtask : do_reset

    function automatic logic [7:0] ra(input int p, input logic [7:0] off);
        return 8'(p) * port_cfg_pkg::OFF_STRIDE + off;
    endfunction : ra

    // Upper nibble marks which of {very weak, weak, strong, down} count
    function automatic logic [7:0] exp_drv(input int i, input logic [1:0] m,
                                           input logic l);
        logic [1:0] md;
        md = m;
        if (i == port_cfg_pkg::FIXED_OD_PIN_A ||
            i == port_cfg_pkg::FIXED_OD_PIN_B) begin
            md = port_cfg_pkg::MODE_OPEN_DRAIN;
        end
        if (i == port_cfg_pkg::RESET_SHARED_PIN) begin
            md = port_cfg_pkg::MODE_INPUT;
        end
        case (md)
            port_cfg_pkg::MODE_QUASI: return {4'hF, l, l, 1'b0, ~l};
            port_cfg_pkg::MODE_PUSH: return {4'h3, 2'b00, l, ~l};
            port_cfg_pkg::MODE_OPEN_DRAIN: return {4'hF, 3'b000, ~l};
            default: return 8'hF0;
        endcase
    endfunction : exp_drv

    initial begin
        logic [31:0] r, ca, cb, la;
        logic        e;
        logic [7:0]  x;
        int          cnt;
        void'($urandom(32'hA451));
        do_reset(1'b1, 1'b0, 1'b0);
        rdchk("latch0", ra(0, port_cfg_pkg::OFF_LATCH), 32'hFF);
        rdchk("cfg_a0", ra(0, port_cfg_pkg::OFF_CFG_A), 32'h0);
        check("vw_reset", {24'h0, vw[7:0]}, 32'hFF);
        check("pin13_irq", {30'h0, ien[13], irq}, 32'h0);
        for (int k = 0; k < 12; k++) begin
            ca = $urandom;
            cb = $urandom;
            la = $urandom;
            for (int p = 0; p < 2; p++) begin
                wr(ra(p, port_cfg_pkg::OFF_CFG_A), {24'h0, ca[p*8+:8]});
                wr(ra(p, port_cfg_pkg::OFF_CFG_B), {24'h0, cb[p*8+:8]});
                wr(ra(p, port_cfg_pkg::OFF_LATCH), {24'h0, la[p*8+:8]});
            end
            ncyc(6);
            for (int i = 0; i < 16; i++) begin
                x = exp_drv(i, {ca[i], cb[i]}, la[i]);
                check("drive", {28'h0, x[7:4] & {vw[i], wk[i], st[i], pd[i]}},
                      {28'h0, x[7:4] & x[3:0]});
            end
            rdchk("cfg_b1", ra(1, port_cfg_pkg::OFF_CFG_B),
                  {24'h0, cb[15:8]});
        end
        for (int p = 0; p < 2; p++) begin
            wr(ra(p, port_cfg_pkg::OFF_CFG_A), 32'h0);
            wr(ra(p, port_cfg_pkg::OFF_CFG_B), 32'h0);
            wr(ra(p, port_cfg_pkg::OFF_LATCH), 32'hFF);
        end
        wr(ra(1, port_cfg_pkg::OFF_LATCH), 32'hFE);
        ncyc(4);
        wr(ra(1, port_cfg_pkg::OFF_LATCH), 32'hFF);
        cnt = 0;
        repeat (8) begin
            @(negedge clock);
            cnt += st[8];
        end
        check("strong_len", 32'(cnt), 32'h2);
        wr(ra(2, port_cfg_pkg::OFF_CFG_A), 32'hF4);
        ncyc(2);
        check("p2_enables", {29'h0, t0, t1, ck}, 32'h7);
        check("schmitt", {14'h0, sch}, 32'h0003_2CFF);
        wr(ra(2, port_cfg_pkg::OFF_CFG_A), 32'h0);
        ncyc(2);
        check("p2_off", {29'h0, t0, t1, ck}, 32'h0);
        check("schmitt_ttl", {14'h0, sch}, 32'h0000_2C00);
        apb(1'b0, 8'h3C, 32'h0, r, e);
        check("unmapped_err", {31'h0, e}, 32'h1);
        check("unmapped_data", r, 32'h0);
        wr(port_cfg_pkg::OFF_KEY_MASK, 32'h08);
        wr(port_cfg_pkg::OFF_AUX, 32'h2);
        wr(port_cfg_pkg::OFF_IRQ_EN, 32'h1);
        wr(port_cfg_pkg::OFF_IRQ_STAT, 32'h1);
        rdchk("stat_ro", port_cfg_pkg::OFF_IRQ_STAT, 32'h0);
        press(18'h00020);
        ncyc(8);
        check("masked_key", {31'h0, irq}, 32'h0);
        // Pins 10 and 11 are held low too so the pin read is fixed
        press(18'h00C08);
        ncyc(3);
        check("sync_delay", {31'h0, irq}, 32'h0);
        ncyc(3);
        check("key_irq", {31'h0, irq}, 32'h1);
        rdchk("pin_read", port_cfg_pkg::OFF_PIN_READ, 32'h0003_D3F7);
        press('0);
        ncyc(6);
        check("flag_held", {31'h0, irq}, 32'h1);
        rdchk("aux_flag", port_cfg_pkg::OFF_AUX, 32'h3);
        wr(port_cfg_pkg::OFF_IRQ_EN, 32'h0);
        ncyc(2);
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr(port_cfg_pkg::OFF_IRQ_EN, 32'h1);
        ncyc(2);
        check("irq_unmasked", {31'h0, irq}, 32'h1);
        wr(port_cfg_pkg::OFF_IRQ_CLR, 32'h1);
        ncyc(2);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        wr(port_cfg_pkg::OFF_AUX, 32'h0);
        press(18'h00008);
        ncyc(6);
        check("inactive", {31'h0, irq}, 32'h0);
        wr(port_cfg_pkg::OFF_AUX, 32'h2);
        press('0);
        ncyc(6);
        rdchk("aux_set", port_cfg_pkg::OFF_AUX, 32'h3);
        wr(port_cfg_pkg::OFF_AUX, 32'h2);
        rdchk("aux_clear", port_cfg_pkg::OFF_AUX, 32'h2);
        do_reset(1'b0, 1'b1, 1'b1);
        rdchk("latch1_low", ra(1, port_cfg_pkg::OFF_LATCH), 32'h0);
        check("low_drive", {30'h0, vw[0], pd[0]}, 32'h1);
        check("pin13_in", {31'h0, ien[13]}, 32'h1);
        check("osc_off", {22'h0, ien[17:16], vw[17:16], st[17:16],
                          pd[17:16], wk[17:16]}, 32'h0);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        final_report();
    end
endmodule : port_config_keypad_wake_test
